// file: design/ring_pkg.sv
/*
 Constants and carrier types for the ringing-wave PWM sequencer.
 Assumes a single 40 MHz clock; all intervals are counted on it.
*/
package ring_pkg;
    localparam int CLK_HZ = 40_000_000;
    // Switching period: 96 kHz nominal
    localparam int PWM_HZ = 96_000;
    localparam logic [8:0] PWM_PERIOD = 9'(CLK_HZ / PWM_HZ);
    // Ringing frequency and sine table layout
    localparam int RING_HZ = 20;
    localparam int TABLE_LEN = 32;
    localparam logic [4:0] TABLE_LAST = 5'h1f;
    localparam int SAMPLE_CYC = CLK_HZ / (RING_HZ * 2 * TABLE_LEN);
    localparam logic [15:0] SAMPLE_CYC_M1 = 16'(SAMPLE_CYC - 1);
    // Amplitude step range
    localparam logic [4:0] STEP_NOM = 5'h10;
    localparam logic [4:0] STEP_MAX = 5'h1f;
    // Current-limit pulses per half cycle; more than this means overload
    localparam logic [7:0] CL_THRESH = 8'h08;
    // Protection timing
    localparam int OVL_MS = 300;
    localparam int SHUT_MS = 4860;
    localparam longint OVL_CYC = longint'(CLK_HZ) * OVL_MS / 1000;
    localparam longint SHUT_CYC = longint'(CLK_HZ) * SHUT_MS / 1000;
    // Zero-crossing pulse: starts this many table entries before crossing
    localparam logic [4:0] SYNC_LEAD = 5'h01;
    localparam logic [4:0] SYNC_TAIL = 5'h01;
    // Half cycles per full sine period
    localparam logic [1:0] HALVES_PER_PERIOD = 2'h2;

    typedef enum {ST_RUN, ST_COUNT, ST_SHUT} prot_state_t;

    // Outputs towards the power stage, bridge and relays
    typedef struct packed {
        logic switch_on;
        logic bridge_polarity;
        logic zero_cross;
        logic overload;
    } stage_out_t;
endpackage : ring_pkg

// file: design/ring_wave_pwm_sequencer.sv
/*
 Ringing-wave PWM sequencer: sine-table PWM with amplitude stepping,
 overload shutdown, bridge polarity and zero-crossing outputs.
 Assumes inputs synchronous to clk; reset driven from the inhibit input.
*/
module ring_wave_pwm_sequencer
    import ring_pkg::*;
#(
    parameter longint OVL_CYCLES = OVL_CYC,
    parameter longint SHUT_CYCLES = SHUT_CYC,
    parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic current_limit_in,
    input wire logic comparator_feedback_in,
    output logic pwm_out,
    output logic bridge_polarity_out,
    output logic zero_cross_out,
    output logic overload_flag_out,
    output stage_out_t stage_r
);
    localparam logic [27:0] OVL_LIM = 28'(OVL_CYCLES - 1);
    localparam logic [27:0] SHUT_LIM = 28'(SHUT_CYCLES - 1);
    // Clocks per table entry; shortened only to keep bench runs brief
    localparam logic [15:0] SAMP_LIM = 16'(SAMPLE_CYCLES - 1);

    logic [8:0] pwm_cnt_r;
    logic [15:0] samp_cnt_r;
    logic [4:0] idx_r;
    logic [4:0] step_r;
    logic [7:0] cl_cnt_r;
    logic cl_prev_r;
    logic cut_r;
    logic [1:0] calm_r;
    logic [27:0] prot_cnt_r;
    prot_state_t prot_r;
    logic [8:0] duty;
    logic period_end;
    logic half_end;
    logic samp_end;
    logic [7:0] sine_val;
    logic fb_unused;

    // Half sine of 32 entries, every entry listed in the table
    function automatic logic [7:0] sine_lut(input logic [4:0] i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            5'h00: v = 8'h00; 5'h01: v = 8'h19; 5'h02: v = 8'h31; 5'h03: v = 8'h4a;
            5'h04: v = 8'h61; 5'h05: v = 8'h78; 5'h06: v = 8'h8e; 5'h07: v = 8'ha2;
            5'h08: v = 8'hb5; 5'h09: v = 8'hc5; 5'h0a: v = 8'hd4; 5'h0b: v = 8'he1;
            5'h0c: v = 8'heb; 5'h0d: v = 8'hf4; 5'h0e: v = 8'hfa; 5'h0f: v = 8'hfe;
            5'h10: v = 8'hff; 5'h11: v = 8'hfe; 5'h12: v = 8'hfa; 5'h13: v = 8'hf4;
            5'h14: v = 8'heb; 5'h15: v = 8'he1; 5'h16: v = 8'hd4; 5'h17: v = 8'hc5;
            5'h18: v = 8'hb5; 5'h19: v = 8'ha2; 5'h1a: v = 8'h8e; 5'h1b: v = 8'h78;
            5'h1c: v = 8'h61; 5'h1d: v = 8'h4a; 5'h1e: v = 8'h31; 5'h1f: v = 8'h19;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : sine_lut

    // Line compensation is outside this block; the input is kept for the pin
    assign fb_unused = comparator_feedback_in;
    assign sine_val = sine_lut(idx_r);
    assign period_end = (pwm_cnt_r == PWM_PERIOD - 9'h001);
    assign samp_end = (samp_cnt_r == SAMP_LIM);
    assign half_end = samp_end && (idx_r == TABLE_LAST);

    // Duty = table * period * 16 / 256 / step, bounded by the period
    always_comb begin
        logic [20:0] num;
        num = 21'(sine_val) * 21'(PWM_PERIOD) * 21'(STEP_NOM);
        duty = 9'((num >> 8) / 21'(step_r));
    end

    // Switching period counter
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwm_cnt_r <= 9'h000;
        end else if (period_end) begin
            pwm_cnt_r <= 9'h000;
        end else begin
            pwm_cnt_r <= pwm_cnt_r + 9'h001;
        end
    end

    // Sine table stepping
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            samp_cnt_r <= 16'h0000;
            idx_r <= 5'h00;
        end else if (samp_end) begin
            samp_cnt_r <= 16'h0000;
            idx_r <= idx_r + 5'h01;
        end else begin
            samp_cnt_r <= samp_cnt_r + 16'h0001;
        end
    end

    // Current-limit cut holds until the switching period ends
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cut_r <= 1'b0;
        end else if (period_end) begin
            cut_r <= 1'b0;
        end else if (!current_limit_in) begin
            cut_r <= 1'b1;
        end
    end

    // Switch drive, cut at once by current limit or shutdown
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (prot_r != ST_SHUT) && current_limit_in && !cut_r
                && !period_end && (pwm_cnt_r < duty);
        end
    end

    // Count falling edges of current limit per half cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cl_prev_r <= 1'b1;
            cl_cnt_r <= 8'h00;
        end else begin
            cl_prev_r <= current_limit_in;
            if (half_end) begin
                cl_cnt_r <= 8'h00;
            end else if (cl_prev_r && !current_limit_in && cl_cnt_r != 8'hff) begin
                cl_cnt_r <= cl_cnt_r + 8'h01;
            end
        end
    end

    // Amplitude step adjusted once per half cycle, forced to STEP_MAX during shutdown
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            step_r <= STEP_NOM;
        end else if (prot_r == ST_SHUT) begin
            step_r <= STEP_MAX;
        end else if (half_end) begin
            if (cl_cnt_r > CL_THRESH && step_r != STEP_MAX) begin
                step_r <= step_r + 5'h01;
            end else if (cl_cnt_r == 8'h00 && step_r != STEP_NOM) begin
                step_r <= step_r - 5'h01;
            end
        end
    end

    // Overload protection: count at minimum amplitude, then shut down
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prot_r <= ST_RUN;
            prot_cnt_r <= 28'h0000000;
        end else begin
            case (prot_r)
                ST_RUN: begin
                    prot_cnt_r <= 28'h0000000;
                    if (step_r == STEP_MAX && half_end && cl_cnt_r > CL_THRESH) begin
                        prot_r <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (half_end && cl_cnt_r == 8'h00) begin
                        prot_r <= ST_RUN;
                    end else if (prot_cnt_r == OVL_LIM) begin
                        prot_r <= ST_SHUT;
                        prot_cnt_r <= 28'h0000000;
                    end else begin
                        prot_cnt_r <= prot_cnt_r + 28'h0000001;
                    end
                end
                ST_SHUT: begin
                    if (prot_cnt_r == SHUT_LIM) begin
                        prot_r <= ST_RUN;
                        prot_cnt_r <= 28'h0000000;
                    end else begin
                        prot_cnt_r <= prot_cnt_r + 28'h0000001;
                    end
                end
                default: begin
                    prot_r <= ST_RUN;
                end
            endcase
        end
    end

    // Bridge polarity toggles at each table wrap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bridge_polarity_out <= 1'b0;
        end else if (half_end) begin
            bridge_polarity_out <= !bridge_polarity_out;
        end
    end

    // Zero-crossing pulse, leading the wrap by a fixed table entry
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            zero_cross_out <= 1'b0;
        end else begin
            zero_cross_out <= (idx_r >= TABLE_LAST - SYNC_LEAD + 5'h01) || (idx_r < SYNC_TAIL);
        end
    end

    // Overload flag with one-period hold at nominal step
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            overload_flag_out <= 1'b0;
            calm_r <= 2'h0;
        end else if (step_r != STEP_NOM) begin
            overload_flag_out <= 1'b1;
            calm_r <= 2'h0;
        end else if (half_end && overload_flag_out) begin
            if (calm_r == HALVES_PER_PERIOD - 2'h1) begin
                overload_flag_out <= 1'b0;
                calm_r <= 2'h0;
            end else begin
                calm_r <= calm_r + 2'h1;
            end
        end
    end

    // Bundled copy of the stage outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage_r <= '0;
        end else begin
            stage_r <= '{switch_on: pwm_out, bridge_polarity: bridge_polarity_out,
                         zero_cross: zero_cross_out, overload: overload_flag_out};
        end
    end

    // Assertions
    shut_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (prot_r == ST_SHUT) |=> !pwm_out)
        else $error("switch active during shutdown");
    cl_cut_a: assert property (@(posedge clk) disable iff (reset)
        !current_limit_in |=> !pwm_out)
        else $error("switch on after current limit");
    step_range_a: assert property (@(posedge clk) disable iff (reset)
        step_r >= STEP_NOM && step_r <= STEP_MAX)
        else $error("step out of range");
    step_hold_a: assert property (@(posedge clk) disable iff (reset)
        (!half_end && prot_r != ST_SHUT && $past(prot_r) != ST_SHUT) |=> $stable(step_r))
        else $error("step changed mid half cycle");
    flag_high_a: assert property (@(posedge clk) disable iff (reset)
        (step_r > STEP_NOM) |=> overload_flag_out)
        else $error("overload flag low above nominal");
    polarity_a: assert property (@(posedge clk) disable iff (reset)
        half_end |=> (bridge_polarity_out != $past(bridge_polarity_out)))
        else $error("polarity missed wrap");
    cl_reset_a: assert property (@(posedge clk) disable iff (reset)
        half_end |=> (cl_cnt_r == 8'h00))
        else $error("cl count not restarted");
    sync_lead_a: assert property (@(posedge clk) disable iff (reset)
        (idx_r == TABLE_LAST) |=> zero_cross_out)
        else $error("sync not leading crossing");
    ovl_shut_a: assert property (@(posedge clk) disable iff (reset)
        (prot_r == ST_COUNT && prot_cnt_r == OVL_LIM && !half_end) |=> (prot_r == ST_SHUT))
        else $error("no shutdown after count");
endmodule : ring_wave_pwm_sequencer

// file: test/cl_sense_model.sv
/*
 Far-side model: current-sense comparator of the flyback switch.
 Assumes pwm_out from the sequencer; driven at the rising clock edge.
*/
module cl_sense_model
    import ring_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic pwm_out,
    input wire logic overload_en,
    input wire logic [3:0] trip_delay,
    output logic current_limit_in,
    output logic comparator_feedback_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] on_cnt_r;

    // Line sampling unused, feedback grounded
    assign comparator_feedback_in = 1'b0;

    // Cycles the switch has been on
    always_ff @(posedge clk or posedge reset) begin
        if (reset) on_cnt_r <= 4'h0;
        else on_cnt_r <= pwm_out ? on_cnt_r + 4'(on_cnt_r != 4'hf) : 4'h0;
    end

    // Trips low after trip_delay on-cycles when loaded, high again once switch is off
    always_ff @(posedge clk or posedge reset) begin
        if (reset) current_limit_in <= 1'b1;
        else current_limit_in <= !(overload_en && pwm_out && on_cnt_r >= trip_delay);
    end
endmodule : cl_sense_model

// file: test/tb_top.sv
/*
 Self-checking bench for the ringing-wave sequencer: duty shape, current limit,
 zero-crossing lead, bridge polarity and overload stepping over one half cycle.
 Assumes sample timing shortened to 1953 clocks per entry; the run covers about 63000 cycles.
*/
module tb_top;
    import ring_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {string name; int lo; int hi; logic val;} note_t;
    logic clk = 1'b0, reset = 1'b1, cl, fb, ovl_en = 1'b0;
    logic [3:0] trip_delay = 4'h4;
    logic pwm, brg, zc, ovl, prev_cl = 1'b1;
    stage_out_t stage, prev_out;
    int cyc = 0, tcyc = 0, d0 = 0, d1 = 0, fail_count = 0, check_count = 0;
    logic [31:0] seed = 32'd72721;
    note_t notes[$];
    note_t n;

    ring_wave_pwm_sequencer #(.OVL_CYCLES(100), .SHUT_CYCLES(200), .SAMPLE_CYCLES(1953)) dut (.clk(clk), .reset(reset),
        .current_limit_in(cl), .comparator_feedback_in(fb), .pwm_out(pwm), .bridge_polarity_out(brg),
        .zero_cross_out(zc), .overload_flag_out(ovl), .stage_r(stage));
    cl_sense_model partner (.clk(clk), .reset(reset), .pwm_out(pwm), .overload_en(ovl_en),
        .trip_delay(trip_delay), .current_limit_in(cl), .comparator_feedback_in(fb));

    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    // Cycle count since reset release, and hang guard
    always @(posedge clk) begin
        tcyc <= tcyc + 1;
        if (!reset) cyc <= cyc + 1;
        if (tcyc == 80000) begin
            fail_count++;
            end_of_test();
        end
    end

    // Output watcher: per-cycle relations and event notes
    always @(negedge clk) begin
        if (reset) check("reset_outs", {pwm, brg, zc, ovl}, 4'h0);
        else begin
            if (cyc > 1) check("stage_copy", stage, prev_out);
            if (!prev_cl) check("cl_cut", pwm, 1'b0);
            if (cyc < 416 && pwm) d0++;
            if (cyc >= 30000 && cyc < 30416 && pwm) d1++;
            if ((zc && !prev_out.zero_cross) || brg !== prev_out.bridge_polarity || (ovl && !prev_out.overload)) begin
                if (notes.size() == 0) check("unexpected_event", 1'b1, 1'b0);
                else begin
                    n = notes.pop_front();
                    check(n.name, 32'(cyc >= n.lo && cyc <= n.hi), 1);
                    check({n.name, "_val"}, n.name == "overload" ? ovl : n.name == "bridge" ? brg : zc, n.val);
                end
            end
        end
        prev_out <= {pwm, brg, zc, ovl};
        prev_cl <= cl;
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // Zero-crossing pulse one entry ahead of the half-cycle end, then polarity, then flag
        // Table index starts at zero, so the pulse is already up one cycle after release
        notes.push_back('{"zero_cross", 1, 1, 1'b1});
        notes.push_back('{"zero_cross", 60530, 60560, 1'b1});
        notes.push_back('{"bridge", 62486, 62510, 1'b1});
        notes.push_back('{"overload", 62486, 62530, 1'b1});
        wait (cyc == 31000);
        check("duty_rises", 32'(d1 > d0 && d1 < 416), 1);
        @(posedge clk);
        ovl_en <= 1'b1;
        // Loaded switch trips after a random on-time
        while (cyc < 62600) begin
            @(posedge clk);
            seed = xorshift(seed);
            trip_delay <= 4'h2 + 4'(seed % 6);
        end
        @(negedge clk);
        check("notes_left", notes.size(), 0);
        check("overload_held", ovl, 1'b1);
        end_of_test();
    end
endmodule : tb_top
